// ===== dv/emb_ram_fifo_tb.sv
// Testbench for the block RAM FIFO with dynamic, static and no-flag builds.
// Assumes the user core model drives the data side; bench drives controls.
`include "emb_fifo_params.svh"
`timescale 1ns/1ps
`default_nettype none
module emb_ram_fifo_tb;
  import emb_fifo_pkg::*;
  localparam int LIMIT = 20000;
  logic clk_sys, rstn, wrap_on_full, wrap_on_empty, thr_load;
  clk_mode_t clock_mode;
  logic [`CNT_W-1:0] thr_afull_in, thr_aempty_in, fill_count, afull_thr, aempty_thr;
  logic [`CNT_W-1:0] afull_thr_s;
  logic wr_en, rd_en, wr_pin, rd_pin, ap_clk, ap_din, ap_upd;
  logic [`LOGIC_W-1:0] wr_data, rd_data;
  logic rd_valid, wr_ignored, rd_ignored, full, empty, almost_full, almost_empty;
  logic none_full, none_empty, none_afull, none_aempty;
  int bad_count, n_compared, cycles;

  user_core_model u_user (.clk_sys(clk_sys), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .wr_pin(wr_pin), .rd_pin(rd_pin), .ap_clk(ap_clk), .ap_din(ap_din),
    .ap_upd(ap_upd));
  emb_ram_fifo #(.FLAG_MODE(FLAGS_DYNAMIC)) DUT (.clk_sys(clk_sys), .rstn(rstn),
    .clock_mode(clock_mode), .wr_clk_pin(wr_pin), .rd_clk_pin(rd_pin),
    .wrap_on_full(wrap_on_full), .wrap_on_empty(wrap_on_empty), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en), .thr_load(thr_load), .thr_afull_in(thr_afull_in),
    .thr_aempty_in(thr_aempty_in), .access_path_shift_clk(ap_clk),
    .access_path_din(ap_din), .access_path_update(ap_upd), .rd_data(rd_data),
    .rd_valid(rd_valid), .wr_ignored(wr_ignored), .rd_ignored(rd_ignored), .full(full),
    .empty(empty), .almost_full(almost_full), .almost_empty(almost_empty),
    .fill_count(fill_count), .afull_thr(afull_thr), .aempty_thr(aempty_thr));
  emb_ram_fifo #(.FLAG_MODE(FLAGS_STATIC)) DUT_static (.clk_sys(clk_sys), .rstn(rstn),
    .clock_mode(clock_mode), .wr_clk_pin(wr_pin), .rd_clk_pin(rd_pin),
    .wrap_on_full(wrap_on_full), .wrap_on_empty(wrap_on_empty), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en), .thr_load(thr_load), .thr_afull_in(thr_afull_in),
    .thr_aempty_in(thr_aempty_in), .access_path_shift_clk(ap_clk),
    .access_path_din(ap_din), .access_path_update(ap_upd), .rd_data(), .rd_valid(),
    .wr_ignored(), .rd_ignored(), .full(), .empty(), .almost_full(), .almost_empty(),
    .fill_count(), .afull_thr(afull_thr_s), .aempty_thr());
  emb_ram_fifo #(.FLAG_MODE(FLAGS_NONE)) DUT_none (.clk_sys(clk_sys), .rstn(rstn),
    .clock_mode(clock_mode), .wr_clk_pin(wr_pin), .rd_clk_pin(rd_pin),
    .wrap_on_full(wrap_on_full), .wrap_on_empty(wrap_on_empty), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en), .thr_load(thr_load), .thr_afull_in(thr_afull_in),
    .thr_aempty_in(thr_aempty_in), .access_path_shift_clk(ap_clk),
    .access_path_din(ap_din), .access_path_update(ap_upd), .rd_data(), .rd_valid(),
    .wr_ignored(), .rd_ignored(), .full(none_full), .empty(none_empty),
    .almost_full(none_afull), .almost_empty(none_aempty), .fill_count(), .afull_thr(),
    .aempty_thr());

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      summarize();
    end
  end

  task automatic t_reset();
    check("empty", 10'h1, empty);
    check("almost_empty", 10'h1, almost_empty);
    check("full", 10'h0, full);
    check("afull_thr", `FIX_AFULL_THR, afull_thr);
    check("aempty_thr", `FIX_AEMPTY_THR, aempty_thr);
    check("no-flag build", 10'h0, {6'h00, none_full, none_empty, none_afull, none_aempty});
  endtask

  task automatic t_order();
    u_user.push(3, 8'h11);
    for (int i = 0; i < 3; i++) begin
      u_user.pull();
      check("rd_data", 8'h11 + i[7:0], rd_data);
      check("rd_valid", 10'h1, rd_valid);
    end
    u_user.pull();
    check("rd_ignored", 10'h1, rd_ignored);
    check("rd_valid", 10'h0, rd_valid);
    check("rd_data held", 10'h13, rd_data);
  endtask

  task automatic t_fill_wrap();
    u_user.push(256, 8'h00);
    check("full at 256", 10'h0, full);
    u_user.push(`FIX_AFULL_THR - 256 - 1, 8'h00);
    check("almost_full below", 10'h0, almost_full);
    u_user.push(1, 8'hef);
    check("almost_full", 10'h1, almost_full);
    u_user.push(`PHYS_DEPTH - `FIX_AFULL_THR, 8'hf0);
    check("full at 512", 10'h1, full);
    check("no-flag full", 10'h0, {6'h00, none_full, none_empty, none_afull, none_aempty});
    check("count", `FULL_CNT, fill_count);
    u_user.push(1, 8'h77);
    check("wr_ignored", 10'h1, wr_ignored);
    check("count", `FULL_CNT, fill_count);
    wrap_on_full = 1'b1;
    u_user.push(1, 8'ha5);
    wrap_on_full = 1'b0;
    check("wr_ignored wrap", 10'h0, wr_ignored);
    check("count wrap", `FULL_CNT, fill_count);
    u_user.pull();
    check("overwritten", 10'ha5, rd_data);
    for (int i = 1; i < `PHYS_DEPTH; i++) begin
      u_user.pull();
      check("drain", {2'b00, i[7:0]}, rd_data);
    end
    check("empty", 10'h1, empty);
    wrap_on_empty = 1'b1;
    u_user.pull();
    wrap_on_empty = 1'b0;
    check("replay valid", 10'h1, rd_valid);
    check("replay data", 10'ha5, rd_data);
    check("replay count", 10'h0, fill_count);
  endtask

  task automatic t_thresholds();
    @(negedge clk_sys);
    {thr_afull_in, thr_aempty_in} = {10'h001, 10'h000};
    thr_load = 1'b1;
    @(negedge clk_sys);
    thr_load = 1'b0;
    check("afull_thr", 10'h001, afull_thr);
    check("static thr", `FIX_AFULL_THR, afull_thr_s);
    check("almost_full", 10'h0, almost_full);
    u_user.push(1, 8'h3c);
    check("almost_full", 10'h1, almost_full);
    check("almost_empty", 10'h0, almost_empty);
    u_user.pull();
    u_user.path_load({10'h002, 10'h001});
    repeat (6) @(negedge clk_sys);
    check("path afull", 10'h002, afull_thr);
    check("path aempty", 10'h001, aempty_thr);
    check("static thr", `FIX_AFULL_THR, afull_thr_s);
  endtask

  task automatic t_indep();
    @(negedge clk_sys);
    clock_mode = CLK_INDEP;
    u_user.hold(1'b1, 1'b0);
    repeat (5) @(negedge clk_sys);
    check("no pin edge", 10'h0, fill_count);
    u_user.pulse(u_user.wr_pin);
    check("pin write", 10'h1, fill_count);
    u_user.hold(1'b0, 1'b1);
    u_user.pulse(u_user.rd_pin);
    check("pin read", 10'h0, fill_count);
    u_user.hold(1'b0, 1'b0);
    clock_mode = CLK_SHARED;
  endtask

  initial begin
    {rstn, wrap_on_full, wrap_on_empty, thr_load} = 4'h0;
    clock_mode = CLK_SHARED;
    {thr_afull_in, thr_aempty_in} = 20'h00000;
    {bad_count, n_compared, cycles} = '0;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_order();
    t_fill_wrap();
    t_thresholds();
    t_indep();
    summarize();
  end
endmodule
`default_nettype wire

// ===== dv/user_core_model.sv
// User logic model: writes, reads, strobe pins and access path shifts.
// Assumes the FIFO samples on clk_sys rising edge; drives at falling edge.
`include "emb_fifo_params.svh"
`timescale 1ns/1ps
`default_nettype none
module user_core_model (
  input  wire logic               clk_sys,
  output var  logic               wr_en,
  output var  logic [`LOGIC_W-1:0] wr_data,
  output var  logic               rd_en,
  output var  logic               wr_pin,
  output var  logic               rd_pin,
  output var  logic               ap_clk,
  output var  logic               ap_din,
  output var  logic               ap_upd
);
  initial begin
    {wr_en, rd_en, wr_pin, rd_pin, ap_clk, ap_din, ap_upd} = 7'h00;
    wr_data = 8'h5a;
  end
  task automatic push(input int n, input logic [7:0] start);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      wr_en = 1'b1;
      wr_data = start + i[7:0];
    end
    @(negedge clk_sys);
    wr_en = 1'b0;
    wr_data = ~wr_data;
  endtask
  task automatic pull();
    @(negedge clk_sys);
    rd_en = 1'b1;
    @(negedge clk_sys);
    rd_en = 1'b0;
  endtask
  task automatic hold(input logic w, input logic r);
    @(negedge clk_sys);
    wr_en = w;
    rd_en = r;
  endtask
  // By reference, so the pin moves while the task waits
  task automatic pulse(ref logic pin);
    pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    pin = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  // Reload thresholds through the access path at any time
  task automatic path_load(input logic [19:0] v);
    for (int i = 19; i >= 0; i--) begin
      @(negedge clk_sys);
      ap_din = v[i];
      repeat (3) @(negedge clk_sys);
      pulse(ap_clk);
    end
    ap_din = ~ap_din;
    pulse(ap_upd);
  endtask
endmodule
`default_nettype wire

// ===== logic/emb_fifo_params.svh
// Constants for the block RAM FIFO: sizes, thresholds, reset values.
// Assumes inclusion by bare name from every design file that needs them.
// Notes on behaviour
// R1 - Flags: none, fixed thresholds, or adjustable thresholds
// R2 - Fixed thresholds are constants, never change
// R3 - Adjustable thresholds reload from logic or access path
// R4 - Wrap on full: write counter rolls, keeps writing
// R5 - Wrap on empty: read counter rolls, replays data
// R6 - Shared clock or separate write and read strobing
// R7 - Full flag follows physical depth, not requested
// R8 - Width built before depth: 256x8 on 512x9
// R9 - No more than sixty-four blocks cascaded
// R10 - Read and write ports share one aspect ratio
// R11 - Without wrap, ignore write full, read empty
`ifndef EMB_FIFO_PARAMS_SVH
`define EMB_FIFO_PARAMS_SVH

`define LOGIC_W          8
`define LOGIC_DEPTH      10'h100
`define PHYS_W           9
`define PHYS_DEPTH       512
`define PAD_W            1
`define PTR_W            9
`define CNT_W            10
`define FULL_CNT         10'h200
`define BLOCKS_USED      1
`define MAX_BLOCKS       64
`define WR_PORT_W        9
`define RD_PORT_W        9
`define FIX_AFULL_THR    10'h1f0
`define FIX_AEMPTY_THR   10'h010
`define RST_CNT          10'h000
`define RST_PTR          9'h000
`define RST_DATA         8'h00
`define PATH_SR_W        20
`define RST_PATH_SR      20'h00000
`define PIN_N            5
`define PIN_WCLK         0
`define PIN_RCLK         1
`define PIN_SHIFT        2
`define PIN_DIN          3
`define PIN_UPDATE       4

`endif

// ===== logic/emb_fifo_pkg.sv
// Types shared by the block RAM FIFO files.
// Assumes nothing of its surroundings.
package emb_fifo_pkg;

  typedef enum logic [1:0] {
    FLAGS_NONE,
    FLAGS_STATIC,
    FLAGS_DYNAMIC
  } flag_mode_t;

  typedef enum logic {
    CLK_SHARED,
    CLK_INDEP
  } clk_mode_t;

endpackage

// ===== logic/emb_ram_fifo.sv
// FIFO controller over one physical RAM block with selectable flags,
// wrap modes and shared or pin-strobed write and read timing.
// Assumes user logic on clk_sys; strobe and access path pins asynchronous.
`include "emb_fifo_params.svh"
`timescale 1ns/1ps
`default_nettype none
module emb_ram_fifo
  import emb_fifo_pkg::*;
#(
  parameter flag_mode_t FLAG_MODE = FLAGS_DYNAMIC
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire clk_mode_t         clock_mode,
  input  wire logic              wr_clk_pin,
  input  wire logic              rd_clk_pin,
  input  wire logic              wrap_on_full,
  input  wire logic              wrap_on_empty,
  input  wire logic              wr_en,
  input  wire logic [`LOGIC_W-1:0] wr_data,
  input  wire logic              rd_en,
  input  wire logic              thr_load,
  input  wire logic [`CNT_W-1:0] thr_afull_in,
  input  wire logic [`CNT_W-1:0] thr_aempty_in,
  input  wire logic              access_path_shift_clk,
  input  wire logic              access_path_din,
  input  wire logic              access_path_update,
  output var  logic [`LOGIC_W-1:0] rd_data,
  output var  logic              rd_valid,
  output var  logic              wr_ignored,
  output var  logic              rd_ignored,
  output var  logic              full,
  output var  logic              empty,
  output var  logic              almost_full,
  output var  logic              almost_empty,
  output var  logic [`CNT_W-1:0] fill_count,
  output var  logic [`CNT_W-1:0] afull_thr,
  output var  logic [`CNT_W-1:0] aempty_thr
);

  // Pin synchronisers
  logic [`PIN_N-1:0] pin_bus;
  logic [`PIN_N-1:0] pin_level;
  logic [`PIN_N-1:0] pin_rise;

  always_comb begin
    pin_bus = {access_path_update, access_path_din, access_path_shift_clk,
               rd_clk_pin, wr_clk_pin};
  end

  pin_sync #(
    .W (`PIN_N)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin_in  (pin_bus),
    .level   (pin_level),
    .rise    (pin_rise)
  );

  // Pointer and count state
  logic [`PTR_W-1:0]   wr_ptr_q;
  logic [`PTR_W-1:0]   wr_ptr_d;
  logic [`PTR_W-1:0]   rd_ptr_q;
  logic [`PTR_W-1:0]   rd_ptr_d;
  logic [`CNT_W-1:0]   count_q;
  logic [`CNT_W-1:0]   count_d;
  logic [`LOGIC_W-1:0] rd_data_q;
  logic [`LOGIC_W-1:0] rd_data_d;
  logic                rd_valid_q;
  logic                rd_valid_d;
  logic                wr_ignored_q;
  logic                wr_ignored_d;
  logic                rd_ignored_q;
  logic                rd_ignored_d;
  logic                wr_strobe;
  logic                rd_strobe;
  logic                full_int;
  logic                empty_int;
  logic                wr_ok;
  logic                rd_ok;
  logic                inc;
  logic                dec;
  logic [`RD_PORT_W-1:0] mem_rdata;
  logic [`WR_PORT_W-1:0] mem_wdata;

  always_comb begin
    // Operation timing: every cycle, or on synchronised pin edges
    if (clock_mode == CLK_SHARED) begin // R6
      wr_strobe = wr_en;
      rd_strobe = rd_en;
    end else begin
      wr_strobe = wr_en & pin_rise[`PIN_WCLK];
      rd_strobe = rd_en & pin_rise[`PIN_RCLK];
    end
    full_int  = (count_q == `FULL_CNT); // R7
    empty_int = (count_q == `RST_CNT);
    wr_ok     = wr_strobe & (~full_int | wrap_on_full); // R4 R11
    rd_ok     = rd_strobe & (~empty_int | wrap_on_empty); // R5 R11
    inc       = wr_ok & ~full_int;
    dec       = rd_ok & ~empty_int;
    wr_ptr_d  = wr_ptr_q;
    rd_ptr_d  = rd_ptr_q;
    if (wr_ok) begin
      wr_ptr_d = wr_ptr_q + `PTR_W'(1); // R4
    end
    if (rd_ok) begin
      rd_ptr_d = rd_ptr_q + `PTR_W'(1); // R5
    end
    count_d      = count_q + `CNT_W'(inc) - `CNT_W'(dec);
    rd_data_d    = rd_ok ? mem_rdata[`LOGIC_W-1:0] : rd_data_q;
    rd_valid_d   = rd_ok;
    wr_ignored_d = wr_strobe & ~wr_ok; // R11
    rd_ignored_d = rd_strobe & ~rd_ok; // R11
    // Narrow words ride in the low bits of the wider physical word
    mem_wdata    = {{`PAD_W{1'b0}}, wr_data}; // R8
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_ptr_q     <= `RST_PTR;
      rd_ptr_q     <= `RST_PTR;
      count_q      <= `RST_CNT;
      rd_data_q    <= `RST_DATA;
      rd_valid_q   <= 1'b0;
      wr_ignored_q <= 1'b0;
      rd_ignored_q <= 1'b0;
    end else begin
      wr_ptr_q     <= wr_ptr_d;
      rd_ptr_q     <= rd_ptr_d;
      count_q      <= count_d;
      rd_data_q    <= rd_data_d;
      rd_valid_q   <= rd_valid_d;
      wr_ignored_q <= wr_ignored_d;
      rd_ignored_q <= rd_ignored_d;
    end
  end

  fifo_ram u_fifo_ram (
    .clk_sys (clk_sys),
    .we      (wr_ok),
    .waddr   (wr_ptr_q),
    .wdata   (mem_wdata),
    .raddr   (rd_ptr_q),
    .rdata   (mem_rdata)
  );

  // Threshold state and access path shift register
  logic [`CNT_W-1:0]     afull_thr_q;
  logic [`CNT_W-1:0]     afull_thr_d;
  logic [`CNT_W-1:0]     aempty_thr_q;
  logic [`CNT_W-1:0]     aempty_thr_d;
  logic [`PATH_SR_W-1:0] path_sr_q;
  logic [`PATH_SR_W-1:0] path_sr_d;

  always_comb begin
    path_sr_d    = path_sr_q;
    afull_thr_d  = afull_thr_q;
    aempty_thr_d = aempty_thr_q;
    if (pin_rise[`PIN_SHIFT]) begin
      path_sr_d = {path_sr_q[`PATH_SR_W-2:0], pin_level[`PIN_DIN]};
    end
    if (FLAG_MODE == FLAGS_STATIC) begin
      afull_thr_d  = `FIX_AFULL_THR; // R2
      aempty_thr_d = `FIX_AEMPTY_THR; // R2
    end else if (FLAG_MODE == FLAGS_DYNAMIC) begin
      if (thr_load) begin
        afull_thr_d  = thr_afull_in; // R3
        aempty_thr_d = thr_aempty_in; // R3
      end else if (pin_rise[`PIN_UPDATE]) begin
        afull_thr_d  = path_sr_q[`PATH_SR_W-1:`CNT_W]; // R3
        aempty_thr_d = path_sr_q[`CNT_W-1:0]; // R3
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      afull_thr_q  <= `FIX_AFULL_THR;
      aempty_thr_q <= `FIX_AEMPTY_THR;
      path_sr_q    <= `RST_PATH_SR;
    end else begin
      afull_thr_q  <= afull_thr_d;
      aempty_thr_q <= aempty_thr_d;
      path_sr_q    <= path_sr_d;
    end
  end

  // Status flags, computed from next count so they track it
  logic full_q;
  logic full_d;
  logic empty_q;
  logic empty_d;
  logic afull_q;
  logic afull_d;
  logic aempty_q;
  logic aempty_d;

  always_comb begin
    if (FLAG_MODE == FLAGS_NONE) begin // R1
      full_d   = 1'b0;
      empty_d  = 1'b0;
      afull_d  = 1'b0;
      aempty_d = 1'b0;
    end else begin
      full_d   = (count_d == `FULL_CNT); // R7
      empty_d  = (count_d == `RST_CNT);
      afull_d  = (count_d >= afull_thr_d);
      aempty_d = (count_d <= aempty_thr_d);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      full_q   <= 1'b0;
      empty_q  <= (FLAG_MODE != FLAGS_NONE);
      afull_q  <= 1'b0;
      aempty_q <= (FLAG_MODE != FLAGS_NONE);
    end else begin
      full_q   <= full_d;
      empty_q  <= empty_d;
      afull_q  <= afull_d;
      aempty_q <= aempty_d;
    end
  end

  always_comb begin
    rd_data      = rd_data_q;
    rd_valid     = rd_valid_q;
    wr_ignored   = wr_ignored_q;
    rd_ignored   = rd_ignored_q;
    full         = full_q;
    empty        = empty_q;
    almost_full  = afull_q;
    almost_empty = aempty_q;
    fill_count   = count_q;
    afull_thr    = afull_thr_q;
    aempty_thr   = aempty_thr_q;
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_indep_write_no_edge;
    clock_mode == CLK_INDEP && wr_en && !pin_rise[`PIN_WCLK];
  endsequence

  sequence s_shared_write_room;
    clock_mode == CLK_SHARED && wr_en && !full_int;
  endsequence

  sequence s_path_update;
    FLAG_MODE == FLAGS_DYNAMIC && pin_rise[`PIN_UPDATE] && !thr_load;
  endsequence

  property p_no_flags;
    FLAG_MODE == FLAGS_NONE |-> !full && !empty && !almost_full && !almost_empty;
  endproperty
  a_no_flags: assert property (p_no_flags) else $error("flags active in no-flag mode"); // R1

  property p_static_thr;
    FLAG_MODE == FLAGS_STATIC |-> afull_thr == `FIX_AFULL_THR
      && aempty_thr == `FIX_AEMPTY_THR;
  endproperty
  a_static_thr: assert property (p_static_thr) else $error("fixed threshold moved"); // R2

  property p_dyn_load;
    FLAG_MODE == FLAGS_DYNAMIC && thr_load |=> afull_thr == $past(thr_afull_in)
      && aempty_thr == $past(thr_aempty_in);
  endproperty
  a_dyn_load: assert property (p_dyn_load) else $error("threshold load lost"); // R3

  property p_path_load;
    s_path_update |=> afull_thr == $past(path_sr_q[`PATH_SR_W-1:`CNT_W])
      && aempty_thr == $past(path_sr_q[`CNT_W-1:0]);
  endproperty
  a_path_load: assert property (p_path_load) else $error("access path load lost"); // R3

  property p_wrap_write;
    full_int && wr_strobe && wrap_on_full |=> wr_ptr_q == $past(wr_ptr_q) + `PTR_W'(1)
      && !wr_ignored;
  endproperty
  a_wrap_write: assert property (p_wrap_write) else $error("wrap write not taken"); // R4

  property p_wrap_read;
    empty_int && rd_strobe && wrap_on_empty |=> rd_ptr_q == $past(rd_ptr_q) + `PTR_W'(1)
      && rd_valid && count_q == `CNT_W'($past(wr_ok));
  endproperty
  a_wrap_read: assert property (p_wrap_read) else $error("replay read not taken"); // R5

  property p_indep_hold;
    s_indep_write_no_edge |=> $stable(wr_ptr_q);
  endproperty
  a_indep_hold: assert property (p_indep_hold) else $error("write without strobe edge"); // R6

  property p_shared_take;
    s_shared_write_room |=> wr_ptr_q == $past(wr_ptr_q) + `PTR_W'(1);
  endproperty
  a_shared_take: assert property (p_shared_take) else $error("shared write not taken"); // R6

  property p_full_phys;
    FLAG_MODE != FLAGS_NONE |-> full == (fill_count == `FULL_CNT)
      && !(full && fill_count == `LOGIC_DEPTH);
  endproperty
  a_full_phys: assert property (p_full_phys) else $error("full flag depth wrong"); // R7

  property p_width_first;
    `PHYS_W >= `LOGIC_W && `PHYS_W - `LOGIC_W == `PAD_W
      && `FULL_CNT >= `LOGIC_DEPTH;
  endproperty
  a_width_first: assert property (p_width_first) else $error("block shape not width first"); // R8

  property p_block_limit;
    `BLOCKS_USED <= `MAX_BLOCKS;
  endproperty
  a_block_limit: assert property (p_block_limit) else $error("too many blocks"); // R9

  property p_aspect;
    `WR_PORT_W == `RD_PORT_W;
  endproperty
  a_aspect: assert property (p_aspect) else $error("port aspect ratios differ"); // R10

  property p_ignore_write;
    full_int && wr_strobe && !wrap_on_full |=> $stable(wr_ptr_q)
      && count_q == $past(count_q) - `CNT_W'($past(rd_ok)) && wr_ignored;
  endproperty
  a_ignore_write: assert property (p_ignore_write) else $error("write taken while full"); // R11

  property p_ignore_read;
    empty_int && rd_strobe && !wrap_on_empty && !wr_ok |=> $stable(rd_ptr_q)
      && rd_ignored && !rd_valid;
  endproperty
  a_ignore_read: assert property (p_ignore_read) else $error("read taken while empty"); // R11

endmodule
`default_nettype wire

// ===== logic/fifo_ram.sv
// Physical RAM block: one write port, one read port, same word shape.
// Assumes pointers and write strobe from the controller on clk_sys.
`include "emb_fifo_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fifo_ram (
  input  wire logic               clk_sys,
  input  wire logic               we,
  input  wire logic [`PTR_W-1:0]  waddr,
  input  wire logic [`WR_PORT_W-1:0] wdata,
  input  wire logic [`PTR_W-1:0]  raddr,
  output var  logic [`RD_PORT_W-1:0] rdata
);

  logic [`PHYS_W-1:0] mem [0:`PHYS_DEPTH-1];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_comb begin
    rdata = mem[raddr];
  end

endmodule
`default_nettype wire

// ===== logic/pin_sync.sv
// Two-flop synchronisers with rising-edge detect, one per pin.
// Assumes asynchronous pins; edge pulses last one clk_sys cycle.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] level,
  output var  logic [W-1:0] rise
);

  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
      // Each bit keeps its own flops so no variable has two writers
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pin_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign level[gi] = s2_q;
      assign rise[gi]  = s2_q & ~s3_q;
    end
  endgenerate

endmodule
`default_nettype wire
